// ===== fsb_top.sv
// Frequency stage blocking, status, timing, event and fault record logic
module fsb_top #(
  parameter int unsigned MS_CLKS = fsb_pkg::MS_CLKS_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Measurement and blocking
  input wire logic [15:0] freq_meas,
  input wire logic [2:0] setting_group_number,
  input wire logic block_in,
  // Stage outputs
  output logic [7:0] stage_start,
  output logic [7:0] stage_trip,
  output logic [7:0] stage_blocked,
  // Event stream
  output logic ev_valid,
  output logic [7:0] ev_block_id,
  output logic [2:0] ev_stage,
  output logic [1:0] ev_kind,
  output logic ev_on,
  output logic [31:0] ev_time,
  output logic [15:0] ev_freq,
  output logic [15:0] ev_pre_freq,
  output logic [15:0] ev_start_freq,
  output logic hmi_block_note
);

  typedef struct packed {
    logic [31:0] stamp;
    logic [5:0] code;
    logic [15:0] pre;
    logic [15:0] fault;
    logic [2:0] sg;
  } fsb_rec_t;

  typedef struct packed {
    logic [2:0] ln_mode;
    logic force_en;
    logic sw_block;
    logic sel_on;
    logic sel_off;
    logic [2:0] sel;
    logic [7:0] stage_en;
    logic [7:0][1:0] force_st;
    logic [7:0][18:0] optime;
    logic [7:0][15:0] fset;
    logic [17:0] ms_div;
    logic [2:0] cyc_ms;
    logic [31:0] ms_time;
    logic blk_s1;
    logic blk_s2;
    logic [7:0] pick;
    logic [7:0] run;
    logic [7:0][18:0] timer;
    logic [7:0] start;
    logic [7:0] trip;
    logic [7:0] blocked;
    logic [23:0] pend;
    logic [23:0] snap;
    logic [31:0] snap_time;
    logic [15:0] snap_freq;
    logic [15:0] snap_pre;
    logic [2:0] snap_sg;
    logic [3:0][15:0] fhist;
    logic [15:0] start_freq;
    logic [15:0] cnt_start;
    logic [15:0] cnt_trip;
    logic [15:0] cnt_block;
    fsb_rec_t [11:0] rec;
    logic [3:0] rec_wp;
    logic [3:0] rec_cnt;
    logic [3:0] rec_sel;
    logic div_go;
    logic div_wait;
    logic [14:0] ratio;
    logic ev_valid;
    logic [2:0] ev_stage;
    logic [1:0] ev_kind;
    logic ev_on;
    logic [31:0] ev_time;
    logic [15:0] ev_freq;
    logic [15:0] ev_pre;
    logic [15:0] ev_start_freq;
    logic hmi_note;
    logic [31:0] rdata;
  } fsb_top_state_t;

  fsb_top_state_t s;
  fsb_top_state_t next_s;
  fsb_div_if div ();

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Word of an eight-stage bank of registers
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a[7:5] == base[7:5]) && (a[1:0] == 2'h0);
  endfunction

  // Pick-up with drop-out hysteresis held below or above the setting
  function automatic logic pick_fn(input logic over, input logic was,
    input logic [15:0] f, input logic [15:0] set);
    logic [16:0] fx;
    logic [16:0] sx;
    fx = {1'b0, f};
    sx = {1'b0, set};
    if (over)
      return was ? (fx + fsb_pkg::HYST_LSB > sx) : (fx > sx);
    else
      return was ? (fx < sx + fsb_pkg::HYST_LSB) : (fx < sx);
  endfunction

  // ==========================================================================
  // Ratio divider, run continuously on the selected stage
  // ==========================================================================
  fsb_div u_div (
    .sys_clk (sys_clk),
    .srst (srst),
    .div (div)
  );

  assign div.start = s.div_go;
  assign div.dividend = 26'(s.fhist[0]) * fsb_pkg::RATIO_SCALE;
  assign div.divisor = s.fset[s.sel];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    logic ms_tick;
    logic cyc_tick;
    logic blk;
    logic active;
    logic pk;
    logic found;
    logic [4:0] j;
    logic [23:0] now_v;
    logic [2:0] idx;
    logic [19:0] remain;
    ms_tick = 1'b0;
    cyc_tick = 1'b0;
    blk = 1'b0;
    active = 1'b0;
    pk = 1'b0;
    found = 1'b0;
    j = '0;
    now_v = '0;
    idx = addr[4:2];
    remain = {1'b0, s.optime[s.sel]} - {1'b0, s.timer[s.sel]};
    next_s = s;
    next_s.ev_valid = 1'b0;
    next_s.hmi_note = 1'b0;
    next_s.div_go = 1'b0;
    next_s.rdata = '0;

    // Block pin synchroniser; the first stage feeds only the second
    next_s.blk_s1 = block_in;
    next_s.blk_s2 = s.blk_s1;

    // Millisecond time base and 5 ms processing cycle
    if (s.ms_div == '0)
    begin
      next_s.ms_div = 18'(MS_CLKS - 1);
      ms_tick = 1'b1;
      next_s.ms_time = s.ms_time + 32'h1;
      if (s.cyc_ms == 3'(fsb_pkg::CYCLE_MS - 1))
      begin
        next_s.cyc_ms = '0;
        cyc_tick = 1'b1;
      end
      else
        next_s.cyc_ms = s.cyc_ms + 3'h1;
    end
    else
      next_s.ms_div = s.ms_div - 18'h1;

    // Stage evaluation once per processing cycle
    if (cyc_tick)
    begin
      blk = s.blk_s2 || (s.force_en && s.sw_block);
      if (s.ln_mode == fsb_pkg::LN_BLOCKED || s.ln_mode == fsb_pkg::LN_TEST_BLOCKED)
        blk = 1'b1;
      next_s.fhist = {s.fhist[2:0], freq_meas};
      for (int i = 0; i < fsb_pkg::NSTAGE; i++)
      begin
        active = s.stage_en[i] && (s.ln_mode != fsb_pkg::LN_OFF);
        pk = active && pick_fn(i < fsb_pkg::NOVER, s.pick[i], freq_meas, s.fset[i]);
        next_s.pick[i] = pk;
        next_s.run[i] = pk && !blk;
        next_s.blocked[i] = pk && blk;
        if (pk && !blk && s.run[i])
          next_s.timer[i] = (s.timer[i] == '1) ? s.timer[i] : s.timer[i] + 19'h1;
        else
          next_s.timer[i] = '0;
        next_s.start[i] = next_s.run[i];
        // Fixed delay, no dependence on the deviation
        next_s.trip[i] = next_s.run[i] && (next_s.timer[i] >= s.optime[i]);
        if (s.force_en)
        begin
          next_s.start[i] = (s.force_st[i] == fsb_pkg::COND_START)
            || (s.force_st[i] == fsb_pkg::COND_TRIP);
          next_s.trip[i] = (s.force_st[i] == fsb_pkg::COND_TRIP);
          next_s.blocked[i] = (s.force_st[i] == fsb_pkg::COND_BLOCKED);
        end
      end
      now_v = {next_s.blocked, next_s.trip, next_s.start};
      next_s.pend = s.pend | (now_v ^ s.snap);
      next_s.snap = now_v;
      // One stamp for every change of this cycle, so instant start and trip match
      next_s.snap_time = s.ms_time;
      next_s.snap_freq = freq_meas;
      next_s.snap_pre = s.fhist[fsb_pkg::PRETRIG_DEPTH - 1];
      next_s.snap_sg = setting_group_number;
      if ((next_s.run & ~s.run) != '0)
        next_s.start_freq = freq_meas;
    end

    // Counter clear first, so a simultaneous edge still counts
    if (wr && addr == fsb_pkg::OFF_CNT_CLR)
    begin
      next_s.cnt_start = '0;
      next_s.cnt_trip = '0;
      next_s.cnt_block = '0;
    end

    // Serialise pending changes, lowest first, one per clock
    for (int k = 0; k < 24; k++)
    begin
      if (!found && s.pend[k])
      begin
        found = 1'b1;
        j = 5'(k);
      end
    end
    if (found)
    begin
      next_s.pend[j] = cyc_tick && (now_v[j] != s.snap[j]); // Set wins over clear
      next_s.ev_valid = s.snap[j] ? s.sel_on : s.sel_off;
      next_s.ev_stage = j[2:0];
      next_s.ev_kind = j[4:3];
      next_s.ev_on = s.snap[j];
      next_s.ev_time = s.snap_time;
      next_s.ev_freq = s.snap_freq;
      next_s.ev_pre = s.snap_pre;
      next_s.ev_start_freq = s.start_freq;
      if (s.snap[j])
      begin
        unique case (j[4:3])
          fsb_pkg::KIND_START: next_s.cnt_start = next_s.cnt_start + 16'h1;
          fsb_pkg::KIND_TRIP: next_s.cnt_trip = next_s.cnt_trip + 16'h1;
          default:
          begin
            next_s.cnt_block = next_s.cnt_block + 16'h1;
            next_s.hmi_note = 1'b1;
          end
        endcase
        next_s.rec[s.rec_wp] = {s.snap_time, j[4:3], j[2:0], 1'b1,
          s.snap_pre, s.snap_freq, s.snap_sg};
        next_s.rec_wp = (s.rec_wp == fsb_pkg::REC_DEPTH - 4'h1) ? '0 : s.rec_wp + 4'h1;
        if (s.rec_cnt != fsb_pkg::REC_DEPTH)
          next_s.rec_cnt = s.rec_cnt + 4'h1;
      end
    end

    // Ratio refresh; clamp keeps the range at 0 to 20
    if (!s.div_go && !s.div_wait && !div.busy)
    begin
      next_s.div_go = 1'b1;
      next_s.div_wait = 1'b1;
    end
    if (div.done)
    begin
      next_s.div_wait = 1'b0;
      next_s.ratio = (div.quotient > 26'(fsb_pkg::RATIO_MAX))
        ? fsb_pkg::RATIO_MAX : div.quotient[14:0];
    end

    // Register writes
    if (wr)
    begin
      if (addr == fsb_pkg::OFF_CTRL)
      begin
        next_s.ln_mode = wdata[fsb_pkg::CTRL_LN_LSB +: 3];
        next_s.force_en = wdata[fsb_pkg::CTRL_FORCE_BIT];
        next_s.sw_block = wdata[fsb_pkg::CTRL_SWBLK_BIT];
        next_s.sel_on = wdata[fsb_pkg::CTRL_EVON_BIT];
        next_s.sel_off = wdata[fsb_pkg::CTRL_EVOFF_BIT];
        next_s.sel = wdata[fsb_pkg::CTRL_SEL_LSB +: 3];
      end
      if (addr == fsb_pkg::OFF_STAGE_EN)
        next_s.stage_en = wdata[7:0];
      if (addr == fsb_pkg::OFF_FORCE)
        next_s.force_st = wdata[15:0];
      if (addr == fsb_pkg::OFF_TIME)
        next_s.ms_time = wdata;
      if (addr == fsb_pkg::OFF_REC_SEL)
        next_s.rec_sel = (wdata[3:0] < fsb_pkg::REC_DEPTH) ? wdata[3:0] : '0;
      if (in_bank(addr, fsb_pkg::OFF_OPTIME))
        next_s.optime[idx] = wdata[18:0];
      if (in_bank(addr, fsb_pkg::OFF_FSET))
        next_s.fset[idx] = wdata[15:0];
    end

    // Register reads, data in the following cycle only
    if (rd)
    begin
      unique case (addr)
        fsb_pkg::OFF_CTRL: next_s.rdata = {21'h0, s.sel, 1'b0, s.sel_off, s.sel_on,
          s.sw_block, s.force_en, s.ln_mode};
        fsb_pkg::OFF_STAGE_EN: next_s.rdata = {24'h0, s.stage_en};
        fsb_pkg::OFF_FORCE: next_s.rdata = {16'h0, s.force_st};
        fsb_pkg::OFF_TIME: next_s.rdata = s.ms_time;
        fsb_pkg::OFF_REC_SEL: next_s.rdata = {28'h0, s.rec_sel};
        fsb_pkg::OFF_COND:
        begin
          for (int i = 0; i < fsb_pkg::NSTAGE; i++)
            next_s.rdata[2 * i +: 2] = s.blocked[i] ? fsb_pkg::COND_BLOCKED
              : s.trip[i] ? fsb_pkg::COND_TRIP
              : s.start[i] ? fsb_pkg::COND_START : fsb_pkg::COND_NORMAL;
        end
        fsb_pkg::OFF_RATIO: next_s.rdata = {17'h0, s.ratio};
        fsb_pkg::OFF_REMAIN: next_s.rdata = {{12{remain[19]}}, remain};
        fsb_pkg::OFF_EXPECT: next_s.rdata = {13'h0, s.optime[s.sel]};
        fsb_pkg::OFF_CNT_START: next_s.rdata = {16'h0, s.cnt_start};
        fsb_pkg::OFF_CNT_TRIP: next_s.rdata = {16'h0, s.cnt_trip};
        fsb_pkg::OFF_CNT_BLOCK: next_s.rdata = {16'h0, s.cnt_block};
        fsb_pkg::OFF_BEHAV: next_s.rdata = {29'h0, s.ln_mode};
        fsb_pkg::OFF_REC_TIME: next_s.rdata = s.rec[s.rec_sel].stamp;
        fsb_pkg::OFF_REC_INFO: next_s.rdata = {fsb_pkg::BLOCK_ID, 13'h0,
          s.rec[s.rec_sel].sg, 2'h0, s.rec[s.rec_sel].code};
        fsb_pkg::OFF_REC_FREQ: next_s.rdata = {s.rec[s.rec_sel].pre, s.rec[s.rec_sel].fault};
        fsb_pkg::OFF_REC_COUNT: next_s.rdata = {24'h0, s.rec_wp, s.rec_cnt};
        default:
        begin
          if (in_bank(addr, fsb_pkg::OFF_OPTIME))
            next_s.rdata = {13'h0, s.optime[idx]};
          else if (in_bank(addr, fsb_pkg::OFF_FSET))
            next_s.rdata = {16'h0, s.fset[idx]};
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.ln_mode <= fsb_pkg::LN_ON;
      s.sel_on <= 1'b1;
      s.sel_off <= 1'b1;
      for (int i = 0; i < fsb_pkg::NSTAGE; i++)
      begin
        s.optime[i] <= fsb_pkg::OPTIME_RST;
        s.fset[i] <= (i < fsb_pkg::NOVER) ? fsb_pkg::FSET_OVER_RST : fsb_pkg::FSET_UNDER_RST;
      end
    end
    else
      s <= next_s;
  end

  // Outputs straight from state, except ev_block_id from the package constant
  assign rdata = s.rdata;
  assign stage_start = s.start;
  assign stage_trip = s.trip;
  assign stage_blocked = s.blocked;
  assign ev_valid = s.ev_valid;
  assign ev_block_id = fsb_pkg::BLOCK_ID;
  assign ev_stage = s.ev_stage;
  assign ev_kind = s.ev_kind;
  assign ev_on = s.ev_on;
  assign ev_time = s.ev_time;
  assign ev_freq = s.ev_freq;
  assign ev_pre_freq = s.ev_pre;
  assign ev_start_freq = s.ev_start_freq;
  assign hmi_block_note = s.hmi_note;

endmodule

// ===== fsb_pkg.sv
// Shared constants for the frequency stage block and event logic
package fsb_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_PS = 1000000000;
  localparam int unsigned MS_CLKS_DEF = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned CYCLE_MS = 5;
  localparam int unsigned PRETRIG_MS = 20;
  localparam int unsigned PRETRIG_DEPTH = PRETRIG_MS / CYCLE_MS;
  localparam int unsigned BLOCK_LEAD_MS = 5;

  // ==========================================================================
  // Measurement scaling
  // ==========================================================================
  localparam int unsigned FREQ_LSB_MHZ = 10;
  localparam int unsigned HYST_MHZ = 20;
  localparam logic [16:0] HYST_LSB = 17'(HYST_MHZ / FREQ_LSB_MHZ);
  localparam logic [25:0] RATIO_SCALE = 26'h00003e8;
  localparam logic [14:0] RATIO_MAX = 15'h4e20;

  // ==========================================================================
  // Sizes and encodings
  // ==========================================================================
  localparam int unsigned NSTAGE = 8;
  localparam int unsigned NOVER = 4;
  localparam logic [3:0] REC_DEPTH = 4'hc;
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [2:0] LN_ON = 3'h1;
  localparam logic [2:0] LN_BLOCKED = 3'h2;
  localparam logic [2:0] LN_TEST_BLOCKED = 3'h4;
  localparam logic [2:0] LN_OFF = 3'h5;
  localparam logic [1:0] KIND_START = 2'h0;
  localparam logic [1:0] KIND_TRIP = 2'h1;
  localparam logic [1:0] KIND_BLOCK = 2'h2;
  // Arbitrary function block tag value
  localparam logic [7:0] BLOCK_ID = 8'h01;

  // ==========================================================================
  // Register offsets and fields
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAGE_EN = 8'h04;
  localparam logic [7:0] OFF_FORCE = 8'h08;
  localparam logic [7:0] OFF_CNT_CLR = 8'h0c;
  localparam logic [7:0] OFF_TIME = 8'h10;
  localparam logic [7:0] OFF_REC_SEL = 8'h14;
  localparam logic [7:0] OFF_COND = 8'h20;
  localparam logic [7:0] OFF_RATIO = 8'h24;
  localparam logic [7:0] OFF_REMAIN = 8'h28;
  localparam logic [7:0] OFF_EXPECT = 8'h2c;
  localparam logic [7:0] OFF_CNT_START = 8'h30;
  localparam logic [7:0] OFF_CNT_TRIP = 8'h34;
  localparam logic [7:0] OFF_CNT_BLOCK = 8'h38;
  localparam logic [7:0] OFF_BEHAV = 8'h3c;
  localparam logic [7:0] OFF_REC_TIME = 8'h40;
  localparam logic [7:0] OFF_REC_INFO = 8'h44;
  localparam logic [7:0] OFF_REC_FREQ = 8'h48;
  localparam logic [7:0] OFF_REC_COUNT = 8'h4c;
  localparam logic [7:0] OFF_OPTIME = 8'h80;
  localparam logic [7:0] OFF_FSET = 8'hc0;
  localparam int unsigned CTRL_LN_LSB = 0;
  localparam int unsigned CTRL_FORCE_BIT = 3;
  localparam int unsigned CTRL_SWBLK_BIT = 4;
  localparam int unsigned CTRL_EVON_BIT = 5;
  localparam int unsigned CTRL_EVOFF_BIT = 6;
  localparam int unsigned CTRL_SEL_LSB = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [18:0] OPTIME_RST = 19'h00014;
  localparam logic [15:0] FSET_OVER_RST = 16'h13ec;
  localparam logic [15:0] FSET_UNDER_RST = 16'h1324;

endpackage

// ===== fsb_div_if.sv
// Request and answer signals between the stage logic and the ratio divider
interface fsb_div_if;
  logic start;
  logic [25:0] dividend;
  logic [15:0] divisor;
  logic busy;
  logic done;
  logic [25:0] quotient;

  modport req (output start, output dividend, output divisor,
    input busy, input done, input quotient);
  modport srv (input start, input dividend, input divisor,
    output busy, output done, output quotient);
endinterface

// ===== fsb_div.sv
// Serial restoring divider for the measured to pick-up frequency ratio
module fsb_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Divide request
  fsb_div_if.srv div
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [16:0] rem;
    logic [25:0] quo;
    logic [15:0] dvs;
  } fsb_div_state_t;

  fsb_div_state_t s;
  fsb_div_state_t next_s;

  // ==========================================================================
  // One quotient bit per clock; a zero divisor saturates the quotient
  // ==========================================================================
  always_comb
  begin
    logic [16:0] r;
    r = '0;
    next_s = s;
    next_s.done = 1'b0;
    if (!s.busy && div.start)
    begin
      next_s.busy = 1'b1;
      next_s.cnt = 5'h19;
      next_s.rem = '0;
      next_s.quo = div.dividend;
      next_s.dvs = div.divisor;
    end
    else if (s.busy)
    begin
      r = {s.rem[15:0], s.quo[25]};
      next_s.quo = {s.quo[24:0], 1'b0};
      if (r >= {1'b0, s.dvs})
      begin
        r = r - {1'b0, s.dvs};
        next_s.quo[0] = 1'b1;
      end
      next_s.rem = r;
      next_s.cnt = s.cnt - 5'h01;
      if (s.cnt == 5'h00)
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end

  assign div.busy = s.busy;
  assign div.done = s.done;
  assign div.quotient = s.quo;

endmodule

// ===== fsb_assertions.sv
// Checker on the stage and event ports of fsb_top
module fsb_assertions #(
  parameter int unsigned MS_CLKS = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Stage and event outputs
  input wire logic [7:0] stage_start,
  input wire logic [7:0] stage_trip,
  input wire logic [7:0] stage_blocked,
  input wire logic ev_valid,
  input wire logic [7:0] ev_block_id,
  input wire logic [1:0] ev_kind,
  input wire logic ev_on,
  input wire logic hmi_block_note
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // ==========================================================================
  // Steps: a flag rises, then its notice follows on the stream
  // ==========================================================================
  sequence start_rise;
    (stage_start & ~$past(stage_start)) != 8'h00;
  endsequence
  sequence blk_rise;
    (stage_blocked & ~$past(stage_blocked)) != 8'h00;
  endsequence
  // Fields update even when the pulse is filtered away
  sequence start_ev;
    ##[1:30] (ev_kind == fsb_pkg::KIND_START && ev_on);
  endsequence
  sequence note_seen;
    ##[1:30] hmi_block_note;
  endsequence
  AST_START_BLK: assert property ((stage_start & stage_blocked) == 8'h00)
    else $error("start and blocked together");
  AST_TRIP_BLK: assert property ((stage_trip & stage_blocked) == 8'h00)
    else $error("trip while blocked");
  AST_TRIP_START: assert property ((stage_trip & ~stage_start) == 8'h00)
    else $error("trip without start");
  AST_EV_TAG: assert property (ev_valid |-> ev_block_id == fsb_pkg::BLOCK_ID)
    else $error("event tag wrong");
  AST_EV_KIND: assert property (ev_valid |-> ev_kind != 2'h3)
    else $error("event kind wrong");
  AST_START_EV: assert property (start_rise |-> start_ev)
    else $error("start event missing");
  AST_BLK_NOTE: assert property (blk_rise |-> note_seen)
    else $error("block note missing");
  AST_NOTE_EV: assert property (hmi_block_note |-> ev_kind == fsb_pkg::KIND_BLOCK && ev_on)
    else $error("note without block event");
endmodule
bind fsb_top fsb_assertions #(.MS_CLKS(MS_CLKS)) fsb_assertions_i (.sys_clk, .srst,
  .stage_start, .stage_trip, .stage_blocked, .ev_valid, .ev_block_id, .ev_kind, .ev_on,
  .hmi_block_note);

// ===== fsb_partner.sv
// Blocking matrix and event buffer stand-in for the stage block
module fsb_partner (
  // Clock
  input wire logic sys_clk,
  // Block request and event stream
  input wire logic blk_req,
  input wire logic ev_valid,
  output logic block_in,
  output int ev_count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    block_in = 1'b0;
    ev_count = 0;
  end
  // Registered matrix output; requests lead any expiry by whole ticks
  always @(posedge sys_clk) block_in <= blk_req;
  // Buffer counts every event that reaches it
  always @(posedge sys_clk) if (ev_valid) ev_count <= ev_count + 1;
endmodule

// ===== frequency_stage_block_event_logic_tb.sv
// Self-checking bench for the frequency stage block
module frequency_stage_block_event_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
  typedef struct {logic [15:0] f; logic b; int n; logic [2:0] e; logic [1:0] c;} fsb_row_t;
  logic sys_clk, srst, wr, rd, blk_req, block_in, ev_valid;
  logic [7:0] addr, st, tr, bl;
  logic [31:0] wdata, rdata, d;
  logic [15:0] freq_meas, evf, esf;
  logic evo;
  int n_errors, checks_done, cyc, ev_count, e0;
  // Frequency, block, ticks, expected {blocked,trip,start}, condition
  fsb_row_t rows [6] = '{'{16'h1450, 1'b0, 2, 3'b001, 2'h1}, '{16'h1450, 1'b0, 2, 3'b011, 2'h2},
    '{16'h13eb, 1'b0, 2, 3'b011, 2'h2}, '{16'h13ea, 1'b0, 2, 3'b000, 2'h0},
    '{16'h1450, 1'b1, 2, 3'b100, 2'h3}, '{16'h1388, 1'b0, 2, 3'b000, 2'h0}};
  // Short millisecond keeps a tick at ten clocks
  fsb_top #(.MS_CLKS(2)) fsb_top_i (.sys_clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .freq_meas, .setting_group_number(3'h2), .block_in, .stage_start(st), .stage_trip(tr),
    .stage_blocked(bl), .ev_valid, .ev_block_id(), .ev_stage(), .ev_kind(), .ev_on(evo),
    .ev_time(), .ev_freq(evf), .ev_pre_freq(), .ev_start_freq(esf), .hmi_block_note());
  fsb_partner fsb_partner_i (.sys_clk, .blk_req, .ev_valid, .block_in, .ev_count);
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= srst ? 0 : cyc + 1;
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Inputs change mid-tick; the read sees exactly n ticks of them
  task automatic step(input logic [15:0] f, input logic b, input int n);
    // Phase is tested on an edge only, so the caller's timing cannot skew it
    @(posedge sys_clk);
    repeat (10) if (cyc % 10 != 3) @(posedge sys_clk);
    @(posedge sys_clk);
    freq_meas <= f;
    blk_req <= b;
    repeat (n * 10 - 3) @(posedge sys_clk);
    rd_reg(fsb_pkg::OFF_COND);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("Error at %0t: timed out", $time);
    results();
  end
  initial
  begin
    {srst, wr, rd, blk_req, addr, wdata} = {4'h8, 8'h00, 32'h0};
    {freq_meas, n_errors, checks_done, cyc} = {16'h1388, 96'h0};
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    rd_reg(fsb_pkg::OFF_CTRL);
    `CHK(d, 32'h61)
    rd_reg(fsb_pkg::OFF_OPTIME);
    `CHK(d, 32'h14)
    rd_reg(8'hfc);
    `CHK(d, 32'h0)
    wr_reg(fsb_pkg::OFF_STAGE_EN, 32'h1);
    wr_reg(fsb_pkg::OFF_OPTIME, 32'h3);
    rd_reg(fsb_pkg::OFF_EXPECT);
    `CHK(d, 32'h3)
    // Long enough for a divide that starts after the new frequency
    step(16'h13ec, 1'b0, 8);
    rd_reg(fsb_pkg::OFF_RATIO);
    `CHK(d, 32'h3e8)
    foreach (rows[i])
    begin
      step(rows[i].f, rows[i].b, rows[i].n);
      `CHK({bl[0], tr[0], st[0]}, rows[i].e)
      `CHK(d[1:0], rows[i].c)
    end
    // Block arriving on a started stage
    step(16'h1450, 1'b0, 1);
    step(16'h1450, 1'b1, 1);
    `CHK({bl[0], st[0]}, 2'b10)
    step(16'h1388, 1'b0, 1);
    // Only OFF kinds, then only ON kinds, reach the buffer
    wr_reg(fsb_pkg::OFF_CTRL, 32'h41);
    e0 = ev_count;
    step(16'h1450, 1'b0, 1);
    `CHK(ev_count - e0, 0)
    `CHK({evo, evf, esf}, {1'b1, 32'h14501450})
    step(16'h1388, 1'b0, 1);
    `CHK(ev_count - e0, 1)
    wr_reg(fsb_pkg::OFF_CTRL, 32'h21);
    step(16'h1450, 1'b0, 1);
    step(16'h1388, 1'b0, 1);
    `CHK(ev_count - e0, 2)
    // Thirteen starts wrap the twelve-slot store
    wr_reg(fsb_pkg::OFF_CTRL, 32'h61);
    wr_reg(fsb_pkg::OFF_CNT_CLR, 32'h0);
    repeat (13)
    begin
      step(16'h1450, 1'b0, 1);
      step(16'h1388, 1'b0, 1);
    end
    rd_reg(fsb_pkg::OFF_CNT_START);
    `CHK(d, 32'hd)
    rd_reg(fsb_pkg::OFF_REC_COUNT);
    `CHK(d[3:0], 4'hc)
    // Every forced status
    wr_reg(fsb_pkg::OFF_CTRL, 32'h69);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(fsb_pkg::OFF_FORCE, 32'(k));
      step(16'h1388, 1'b0, 1);
      `CHK(d[1:0], 2'(k))
    end
    // Software block switch keeps the timer cleared to zero, then a late trip goes negative
    wr_reg(fsb_pkg::OFF_CTRL, 32'h79);
    step(16'h1450, 1'b0, 2);
    rd_reg(fsb_pkg::OFF_REMAIN);
    `CHK(d, 32'h3)
    wr_reg(fsb_pkg::OFF_CTRL, 32'h61);
    step(16'h1450, 1'b0, 5);
    rd_reg(fsb_pkg::OFF_REMAIN);
    `CHK(d, 32'hfffffffe)
    // Every behaviour mode, ending switched off
    for (int m = 1; m < 6; m++)
    begin
      wr_reg(fsb_pkg::OFF_CTRL, 32'h60 | 32'(m));
      rd_reg(fsb_pkg::OFF_BEHAV);
      `CHK(d, 32'(m))
    end
    step(16'h1450, 1'b0, 1);
    `CHK({bl[0], tr[0], st[0]}, 3'b000)
    // Reset in mid-run clears a started stage
    wr_reg(fsb_pkg::OFF_CTRL, 32'h61);
    step(16'h1450, 1'b0, 1);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK(st, 8'h00)
    results();
  end
endmodule
